// ==== logic/adc_select_defs.vh ====
// offsets, field positions, reset values and code limits for the
// converter input select block; included by the design files only
`ifndef ADC_SELECT_DEFS_VH
`define ADC_SELECT_DEFS_VH

// register word offsets on the plain register port
`define ADDR_W 3
`define OFS_CH0_SEL 3'h0
`define OFS_SCAN_SEL 3'h1
`define OFS_PORT_CFG 3'h2
`define OFS_MODE_CTRL 3'h3
`define OFS_STATUS 3'h4

// channel 0 select register fields
`define CH0_NEG_B_BIT 15
`define CH0_POS_B_HI 12
`define CH0_POS_B_LO 8
`define CH0_NEG_A_BIT 7
`define CH0_POS_A_HI 4
`define CH0_POS_A_LO 0

// mode control register fields
`define MODE_CH123_BIT 0
`define MODE_ALT_BIT 1
`define MODE_SCAN_BIT 2
`define MODE_12B_BIT 3

// status register fields
`define STAT_PHASE_BIT 0
`define STAT_ANY_BIT 1
`define STAT_PTR_HI 7
`define STAT_PTR_LO 4

// widths and reset values
`define NUM_INPUTS 10
`define MASK_W 10
`define IDX_W 4
`define CODE_W 5
`define REG_RESET 16'h0000
`define MASK_RESET 10'h000
`define MODE_RESET 4'h0

// inputs that have a physical pin on each variant
`define PINS_SIX 10'h0cf
`define PINS_TEN 10'h3ff

// fixed multiplexer routings for channels 1 to 3
`define IDX_IN0 4'h0
`define IDX_IN1 4'h1
`define IDX_IN2 4'h2
`define IDX_IN3 4'h3
`define IDX_IN4 4'h4
`define IDX_IN5 4'h5

`endif

// ==== logic/scan_stepper.v ====
// finds the first enabled scan input and the next one after a pointer
// assumes mask bits index analog inputs 0 to 9
`timescale 1ns/100ps
`include "adc_select_defs.vh"

module scan_stepper
(
   input wire [`MASK_W-1:0] mask,
   input wire [`IDX_W-1:0] ptr,
   output reg [`IDX_W-1:0] first_idx,
   output reg [`IDX_W-1:0] next_idx,
   output reg any_set
);

   integer i;
   reg found;

   // descending walk: the last hit is the lowest index
   always @*
   begin
      first_idx = `IDX_IN0;
      next_idx = `IDX_IN0;
      any_set = 1'b0;
      found = 1'b0;
      for (i = `MASK_W - 1; i >= 0; i = i - 1)
      begin
         if (mask[i])
         begin
            first_idx = i[`IDX_W-1:0];
            any_set = 1'b1;
            if (i[`IDX_W-1:0] > ptr)
            begin
               next_idx = i[`IDX_W-1:0];
               found = 1'b1;
            end
         end
      end
      // wrap to the start of the sequence
      if (!found)
      begin
         next_idx = first_idx;
      end
   end

endmodule // scan_stepper

// ==== logic/adc_input_select.v ====
// converter input multiplexer selection with scan mask and port config
// assumes the register port master and conversion_done share clk
`timescale 1ns/100ps
`include "adc_select_defs.vh"

// How it works
// - six-input, 10-bit: select set routes input 3 to ch1, ch2/ch3 open.
// - ten-input, 10-bit: select set routes inputs 3, 4, 5 to ch1-3.
// - in 12-bit mode both ch1-3 select values are reserved, nothing routed.
// - bit 15 picks ch0 Sample B negative: 1 is input 1, 0 reference.
// - bits 12-8 pick ch0 Sample B positive; six-input codes 4,5 and 8,9 reserved.
// - ten-input codes 0 to 9 map straight to inputs 0 to 9.
// - bit 7 picks ch0 Sample A negative: 1 is input 1, 0 reference.
// - bits 4-0 pick ch0 Sample A positive with the Sample B mapping.
// - channel 0 bits 14-13 and 6-5 ignore writes and read zero.
// - scan mask bit set includes that input in the scan, clear skips it.
// - all scan bits writable; a pinless scan slot samples the reference.
// - six-input part has real inputs 0-3, 6 and 7 only.
// - port bit set: digital read enabled, mux input tied to ground.
// - port bit clear: analog, digital read off, pin voltage sampled.
// - all ten port bits writable; bits without an input do nothing.
// - bits 15-10 of scan and port registers read zero.
// - all implemented bits clear at reset: analog pins, no scanning.
// - alternate mode uses Sample A then Sample B; else always Sample A.
// - scanning steps ch0 Sample A positive through enabled inputs.
module adc_input_select
#(
   parameter TEN_INPUT = 1'b1
)
(
   input wire clk,
   input wire reset,
   input wire [`ADDR_W-1:0] addr,
   input wire [15:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   input wire conversion_done,
   output reg [15:0] rdata_ff,
   output reg sample_b_phase_ff,
   output reg [`IDX_W-1:0] ch0_pos_idx_ff,
   output reg ch0_pos_conn_ff,
   output reg ch0_pos_nref_ff,
   output reg ch0_pos_ground_ff,
   output reg ch0_neg_is_in1_ff,
   output reg [`IDX_W-1:0] ch1_pos_idx_ff,
   output reg [`IDX_W-1:0] ch2_pos_idx_ff,
   output reg [`IDX_W-1:0] ch3_pos_idx_ff,
   output reg [2:0] ch123_pos_conn_ff,
   output reg [`MASK_W-1:0] digital_read_en_ff,
   output reg [`MASK_W-1:0] mux_ground_ff
);

   localparam [`MASK_W-1:0] PIN_MASK = TEN_INPUT ? `PINS_TEN : `PINS_SIX;

   // software registers
   reg ch0_neg_b_ff;
   reg [`CODE_W-1:0] ch0_pos_b_ff;
   reg ch0_neg_a_ff;
   reg [`CODE_W-1:0] ch0_pos_a_ff;
   reg [`MASK_W-1:0] scan_enable_mask_ff;
   reg [`MASK_W-1:0] port_digital_mode_mask_ff;
   reg ch1to3_sample_a_positive_select_ff;
   reg alternate_sample_enable_ff;
   reg channel_scan_enable_ff;
   reg twelve_bit_mode_ff;

   // sequencing state
   reg [`IDX_W-1:0] scan_ptr_ff;
   reg [`IDX_W-1:0] nxt_scan_ptr;
   reg nxt_sample_b_phase;

   wire [`IDX_W-1:0] scan_first;
   wire [`IDX_W-1:0] scan_next;
   wire scan_any;

   // combinational routing
   reg [`CODE_W-1:0] pos_code;
   reg [`IDX_W-1:0] nxt_ch0_idx;
   reg nxt_ch0_conn;
   reg nxt_ch0_nref;
   reg nxt_ch0_ground;
   reg nxt_ch0_neg;
   reg [`IDX_W-1:0] nxt_ch1;
   reg [`IDX_W-1:0] nxt_ch2;
   reg [`IDX_W-1:0] nxt_ch3;
   reg [2:0] nxt_ch123_conn;
   reg [15:0] nxt_rdata;

   scan_stepper u_scan_stepper
   (
      .mask(scan_enable_mask_ff),
      .ptr(scan_ptr_ff),
      .first_idx(scan_first),
      .next_idx(scan_next),
      .any_set(scan_any)
   );

   // register writes; unimplemented bits are simply not stored
   always @(posedge clk)
   begin
      if (reset)
      begin
         ch0_neg_b_ff <= 1'b0;
         ch0_pos_b_ff <= 5'h00;
         ch0_neg_a_ff <= 1'b0;
         ch0_pos_a_ff <= 5'h00;
         scan_enable_mask_ff <= `MASK_RESET;
         port_digital_mode_mask_ff <= `MASK_RESET;
         ch1to3_sample_a_positive_select_ff <= 1'b0;
         alternate_sample_enable_ff <= 1'b0;
         channel_scan_enable_ff <= 1'b0;
         twelve_bit_mode_ff <= 1'b0;
      end
      else if (wr_stb)
      begin
         case (addr)
            `OFS_CH0_SEL:
            begin
               ch0_neg_b_ff <= wdata[`CH0_NEG_B_BIT];
               ch0_pos_b_ff <= wdata[`CH0_POS_B_HI:`CH0_POS_B_LO];
               ch0_neg_a_ff <= wdata[`CH0_NEG_A_BIT];
               ch0_pos_a_ff <= wdata[`CH0_POS_A_HI:`CH0_POS_A_LO];
            end
            `OFS_SCAN_SEL:
            begin
               // every bit stored even on the six-input part
               scan_enable_mask_ff <= wdata[`MASK_W-1:0];
            end
            `OFS_PORT_CFG:
            begin
               port_digital_mode_mask_ff <= wdata[`MASK_W-1:0];
            end
            `OFS_MODE_CTRL:
            begin
               ch1to3_sample_a_positive_select_ff <= wdata[`MODE_CH123_BIT];
               alternate_sample_enable_ff <= wdata[`MODE_ALT_BIT];
               channel_scan_enable_ff <= wdata[`MODE_SCAN_BIT];
               twelve_bit_mode_ff <= wdata[`MODE_12B_BIT];
            end
            default:
            begin
               ch0_neg_b_ff <= ch0_neg_b_ff;
            end
         endcase
      end
   end

   // read data live only in the cycle after the strobe
   always @*
   begin
      nxt_rdata = `REG_RESET;
      case (addr)
         `OFS_CH0_SEL:
         begin
            nxt_rdata[`CH0_NEG_B_BIT] = ch0_neg_b_ff;
            nxt_rdata[`CH0_POS_B_HI:`CH0_POS_B_LO] = ch0_pos_b_ff;
            nxt_rdata[`CH0_NEG_A_BIT] = ch0_neg_a_ff;
            nxt_rdata[`CH0_POS_A_HI:`CH0_POS_A_LO] = ch0_pos_a_ff;
         end
         `OFS_SCAN_SEL:
         begin
            nxt_rdata[`MASK_W-1:0] = scan_enable_mask_ff;
         end
         `OFS_PORT_CFG:
         begin
            nxt_rdata[`MASK_W-1:0] = port_digital_mode_mask_ff;
         end
         `OFS_MODE_CTRL:
         begin
            nxt_rdata[`MODE_CH123_BIT] = ch1to3_sample_a_positive_select_ff;
            nxt_rdata[`MODE_ALT_BIT] = alternate_sample_enable_ff;
            nxt_rdata[`MODE_SCAN_BIT] = channel_scan_enable_ff;
            nxt_rdata[`MODE_12B_BIT] = twelve_bit_mode_ff;
         end
         `OFS_STATUS:
         begin
            nxt_rdata[`STAT_PHASE_BIT] = sample_b_phase_ff;
            nxt_rdata[`STAT_ANY_BIT] = scan_any;
            nxt_rdata[`STAT_PTR_HI:`STAT_PTR_LO] = scan_ptr_ff;
         end
         default:
         begin
            nxt_rdata = `REG_RESET;
         end
      endcase
      if (!rd_stb)
      begin
         nxt_rdata = `REG_RESET;
      end
   end

   // phase advances once per finished conversion; scan pointer only after Sample A ones
   always @*
   begin
      nxt_sample_b_phase = sample_b_phase_ff;
      nxt_scan_ptr = scan_ptr_ff;
      if (!alternate_sample_enable_ff)
      begin
         nxt_sample_b_phase = 1'b0;
      end
      else if (conversion_done)
      begin
         nxt_sample_b_phase = !sample_b_phase_ff;
      end
      if (!channel_scan_enable_ff)
      begin
         // parked on the first slot so a new scan starts at its head
         nxt_scan_ptr = scan_first;
      end
      else if (conversion_done && !sample_b_phase_ff)
      begin
         nxt_scan_ptr = scan_next;
      end
   end

   // channel 0 routing for the current phase
   always @*
   begin
      pos_code = sample_b_phase_ff ? ch0_pos_b_ff : ch0_pos_a_ff;
      nxt_ch0_neg = sample_b_phase_ff ? ch0_neg_b_ff : ch0_neg_a_ff;
      nxt_ch0_idx = pos_code[`IDX_W-1:0];
      nxt_ch0_nref = 1'b0;
      nxt_ch0_conn = 1'b0;
      if (channel_scan_enable_ff && !sample_b_phase_ff)
      begin
         nxt_ch0_idx = scan_ptr_ff;
         if (scan_any && scan_enable_mask_ff[scan_ptr_ff])
         begin
            nxt_ch0_conn = PIN_MASK[scan_ptr_ff];
            nxt_ch0_nref = !PIN_MASK[scan_ptr_ff];
         end
      end
      else if (pos_code < `NUM_INPUTS)
      begin
         // same table for both phases; holes stay open
         nxt_ch0_conn = PIN_MASK[pos_code[`IDX_W-1:0]];
      end
      nxt_ch0_ground = nxt_ch0_conn && port_digital_mode_mask_ff[nxt_ch0_idx];
   end

   // channels 1 to 3 routing
   always @*
   begin
      nxt_ch1 = `IDX_IN0;
      nxt_ch2 = `IDX_IN1;
      nxt_ch3 = `IDX_IN2;
      nxt_ch123_conn = 3'h7;
      if (twelve_bit_mode_ff)
      begin
         nxt_ch123_conn = 3'h0;
      end
      else if (ch1to3_sample_a_positive_select_ff)
      begin
         nxt_ch1 = `IDX_IN3;
         if (TEN_INPUT)
         begin
            nxt_ch2 = `IDX_IN4;
            nxt_ch3 = `IDX_IN5;
         end
         else
         begin
            nxt_ch123_conn = 3'h1;
         end
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         rdata_ff <= `REG_RESET;
         sample_b_phase_ff <= 1'b0;
         scan_ptr_ff <= `IDX_IN0;
         ch0_pos_idx_ff <= `IDX_IN0;
         ch0_pos_conn_ff <= 1'b0;
         ch0_pos_nref_ff <= 1'b0;
         ch0_pos_ground_ff <= 1'b0;
         ch0_neg_is_in1_ff <= 1'b0;
         ch1_pos_idx_ff <= `IDX_IN0;
         ch2_pos_idx_ff <= `IDX_IN0;
         ch3_pos_idx_ff <= `IDX_IN0;
         ch123_pos_conn_ff <= 3'h0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         sample_b_phase_ff <= nxt_sample_b_phase;
         scan_ptr_ff <= nxt_scan_ptr;
         ch0_pos_idx_ff <= nxt_ch0_idx;
         ch0_pos_conn_ff <= nxt_ch0_conn;
         ch0_pos_nref_ff <= nxt_ch0_nref;
         ch0_pos_ground_ff <= nxt_ch0_ground;
         ch0_neg_is_in1_ff <= nxt_ch0_neg;
         ch1_pos_idx_ff <= nxt_ch1;
         ch2_pos_idx_ff <= nxt_ch2;
         ch3_pos_idx_ff <= nxt_ch3;
         ch123_pos_conn_ff <= nxt_ch123_conn;
      end
   end

   // per-pin analog or digital mode; pinless bits held in analog
   genvar g;
   generate
      for (g = 0; g < `MASK_W; g = g + 1)
      begin : g_pin
         always @(posedge clk)
         begin
            if (reset)
            begin
               digital_read_en_ff[g] <= 1'b0;
               mux_ground_ff[g] <= 1'b0;
            end
            else
            begin
               digital_read_en_ff[g] <= port_digital_mode_mask_ff[g] & PIN_MASK[g];
               mux_ground_ff[g] <= port_digital_mode_mask_ff[g] & PIN_MASK[g];
            end
         end
      end
   endgenerate

endmodule // adc_input_select

// ==== test/sample_stage_model.sv ====
// sample stage model: answers a start pulse with one conversion done pulse
// assumes start is one cycle long; slow stretches the conversion time
`timescale 1ns/100ps
module sample_stage_model
(
   input wire clk,
   input wire reset,
   input wire start,
   input wire slow,
   output reg done_ff
);
   reg [3:0] cnt_ff;
   always @(posedge clk)
   begin
      done_ff <= 1'b0;
      if (reset)
         cnt_ff <= 4'h0;
      else if (start)
         cnt_ff <= slow ? 4'h9 : 4'h1;
      else if (cnt_ff != 4'h0)
      begin
         cnt_ff <= cnt_ff - 4'h1;
         done_ff <= (cnt_ff == 4'h1);
      end
   end
endmodule // sample_stage_model

// ==== test/adc_input_select_checker.sv ====
// checker for the converter input select block
// variant follows the bound instance's TEN_INPUT; register copies follow the write port
`timescale 1ns/100ps
module adc_input_select_checker
#(
   parameter TEN_INPUT = 1'b1
)
(
   input wire clk,
   input wire reset,
   input wire [2:0] addr,
   input wire [15:0] wdata,
   input wire wr_stb,
   input wire conversion_done,
   input wire sample_b_phase_ff,
   input wire [3:0] ch0_pos_idx_ff,
   input wire ch0_pos_conn_ff,
   input wire ch0_neg_is_in1_ff,
   input wire [3:0] ch1_pos_idx_ff,
   input wire [3:0] ch3_pos_idx_ff,
   input wire [2:0] ch123_pos_conn_ff,
   input wire [9:0] digital_read_en_ff,
   input wire [9:0] mux_ground_ff
);
   // inputs with a physical pin: all ten, or 0-3, 6 and 7 on the six-input part
   localparam [9:0] PINS = TEN_INPUT ? 10'h3ff : 10'h0cf;
   reg [15:0] ch0_ff;
   reg [9:0] mask_ff;
   reg [9:0] port_ff;
   reg [3:0] mode_ff;
   wire [4:0] sel = sample_b_phase_ff ? ch0_ff[12:8] : ch0_ff[4:0];
   always @(posedge clk)
   begin
      if (reset)
      begin
         ch0_ff <= 16'h0000;
         mask_ff <= 10'h000;
         port_ff <= 10'h000;
         mode_ff <= 4'h0;
      end
      else if (wr_stb)
      begin
         if (addr == 3'h0)
            ch0_ff <= wdata;
         if (addr == 3'h1)
            mask_ff <= wdata[9:0];
         if (addr == 3'h2)
            port_ff <= wdata[9:0];
         if (addr == 3'h3)
            mode_ff <= wdata[3:0];
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // outputs lag the registers by one cycle, so only settled states are judged
   sequence settled;
      !$past(reset) && $stable(ch0_ff) && $stable(mode_ff) && $stable(sample_b_phase_ff)
         && !mode_ff[2];
   endsequence
   sequence quiet_scan;
      mode_ff[2] && !mode_ff[1] && $stable(mode_ff) && $stable(mask_ff) && !$past(conversion_done);
   endsequence
   sequence hop;
      conversion_done && !wr_stb && $countones(mask_ff) > 1 ##1 !wr_stb;
   endsequence
   a_neg_select: assert property (
      settled |-> ch0_neg_is_in1_ff == (sample_b_phase_ff ? ch0_ff[15] : ch0_ff[7]))
      else $error("ch0 negative select wrong");
   a_pos_direct: assert property (
      settled ##0 (sel < 5'd10 && PINS[sel[3:0]]) |-> ch0_pos_conn_ff && ch0_pos_idx_ff == sel[3:0])
      else $error("ch0 positive routing wrong");
   a_pos_reserved: assert property (
      settled ##0 (sel >= 5'd10 || !PINS[sel[3:0]]) |-> !ch0_pos_conn_ff)
      else $error("reserved code connected");
   a_ch123_map: assert property (
      !$past(reset) && $stable(mode_ff) && !mode_ff[3]
         |-> ch123_pos_conn_ff == ((mode_ff[0] && !TEN_INPUT) ? 3'b001 : 3'b111)
         && ch1_pos_idx_ff == {2'b00, mode_ff[0], mode_ff[0]}
         && (!ch123_pos_conn_ff[2] || ch3_pos_idx_ff == (mode_ff[0] ? 4'h5 : 4'h2)))
      else $error("channel 1 to 3 routing wrong");
   a_wide_reserved: assert property (
      $stable(mode_ff) && mode_ff[3] |-> ch123_pos_conn_ff == 3'b000)
      else $error("channels 1 to 3 connected in 12-bit mode");
   a_phase_hold: assert property (
      $stable(mode_ff) && !mode_ff[1] |-> !sample_b_phase_ff)
      else $error("Sample B phase while alternate off");
   a_phase_toggle: assert property (
      mode_ff[1] && $stable(mode_ff) && conversion_done && !wr_stb
         |=> sample_b_phase_ff != $past(sample_b_phase_ff))
      else $error("phase did not alternate");
   a_scan_member: assert property (
      mode_ff[2] && !mode_ff[1] && $stable(mode_ff) && $stable(mask_ff) && ch0_pos_conn_ff
         |-> mask_ff[ch0_pos_idx_ff])
      else $error("scan picked a skipped input");
   a_scan_hop: assert property (
      quiet_scan ##0 hop |=> ch0_pos_idx_ff != $past(ch0_pos_idx_ff, 2))
      else $error("scan did not step");
   a_port_mode: assert property (
      $stable(port_ff) |-> digital_read_en_ff == (port_ff & PINS)
         && mux_ground_ff == (port_ff & PINS))
      else $error("port mode outputs wrong");
endmodule // adc_input_select_checker

bind adc_input_select adc_input_select_checker #(.TEN_INPUT(TEN_INPUT)) chk
   (.clk, .reset, .addr, .wdata, .wr_stb,
   .conversion_done, .sample_b_phase_ff, .ch0_pos_idx_ff, .ch0_pos_conn_ff,
   .ch0_neg_is_in1_ff, .ch1_pos_idx_ff, .ch3_pos_idx_ff, .ch123_pos_conn_ff,
   .digital_read_en_ff, .mux_ground_ff);

// ==== test/adc_input_select_test.sv ====
// self-checking bench for the converter input select block, both variants side by side
// assumes the sample stage model produces conversion_done
`timescale 1ns/100ps
module adc_input_select_test;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg [2:0] addr = 3'h0;
   reg [15:0] wdata = 16'h0000;
   reg wr_stb = 1'b0;
   reg rd_stb = 1'b0;
   reg start = 1'b0;
   reg slow = 1'b0;
   wire done, phase, conn0, gnd0, neg0;
   wire [15:0] rdata;
   wire [3:0] idx0, idx1, idx2, idx3;
   wire [2:0] conn123;
   wire [9:0] dig_en, mux_gnd;
   wire nref0, conn0_s, nref0_s;
   wire [15:0] rdata_s;
   wire [3:0] idx0_s, idx1_s;
   wire [2:0] conn123_s;
   wire [9:0] dig_en_s, mux_gnd_s;
   integer failures = 0;
   integer n_checks = 0;
   integer cycles = 0;
   integer i;
   reg [31:0] seed = 32'h9c8d1333;
   reg [15:0] d;
   reg [2:0] a;
   reg [9:0] port;
   reg [3:0] slot;
   always #50 clk = ~clk;
   adc_input_select #(.TEN_INPUT(1'b1)) DUT (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .conversion_done(done),
      .rdata_ff(rdata), .sample_b_phase_ff(phase), .ch0_pos_idx_ff(idx0),
      .ch0_pos_conn_ff(conn0), .ch0_pos_nref_ff(nref0), .ch0_pos_ground_ff(gnd0),
      .ch0_neg_is_in1_ff(neg0), .ch1_pos_idx_ff(idx1), .ch2_pos_idx_ff(idx2),
      .ch3_pos_idx_ff(idx3), .ch123_pos_conn_ff(conn123), .digital_read_en_ff(dig_en),
      .mux_ground_ff(mux_gnd));
   // six-input variant shares every input with the ten-input one
   adc_input_select #(.TEN_INPUT(1'b0)) dut_six (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .conversion_done(done),
      .rdata_ff(rdata_s), .sample_b_phase_ff(), .ch0_pos_idx_ff(idx0_s),
      .ch0_pos_conn_ff(conn0_s), .ch0_pos_nref_ff(nref0_s), .ch0_pos_ground_ff(),
      .ch0_neg_is_in1_ff(), .ch1_pos_idx_ff(idx1_s), .ch2_pos_idx_ff(), .ch3_pos_idx_ff(),
      .ch123_pos_conn_ff(conn123_s), .digital_read_en_ff(dig_en_s),
      .mux_ground_ff(mux_gnd_s));
   sample_stage_model partner (.clk(clk), .reset(reset), .start(start), .slow(slow),
      .done_ff(done));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // {connected, index}; codes above nine are reserved and stay open
   function [4:0] pos_exp(input [4:0] code);
      pos_exp = (code < 5'd10) ? {1'b1, code[3:0]} : 5'h00;
   endfunction
   // six-input part: codes 0-3, 6 and 7 have pins; 4, 5 and above 7 stay open
   function six_ok(input [4:0] code);
      six_ok = code < 5'd8 && code[2:1] != 2'b10;
   endfunction
   task check(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            failures = failures + 1;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task wr(input [2:0] ad, input [15:0] v);
      begin
         @(posedge clk);
         addr <= ad;
         wdata <= v;
         wr_stb <= 1'b1;
         @(posedge clk);
         wr_stb <= 1'b0;
      end
   endtask
   task rd(input [2:0] ad, input [15:0] exp);
      begin
         @(posedge clk);
         addr <= ad;
         rd_stb <= 1'b1;
         @(posedge clk);
         rd_stb <= 1'b0;
         #1 check(rdata, exp);
         check(rdata_s, exp);
      end
   endtask
   task settle;
      begin
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   task conv(input s);
      integer k;
      begin
         @(posedge clk);
         slow <= s;
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
         for (k = 0; k < 20 && done !== 1'b1; k = k + 1)
            @(posedge clk) #1;
         settle;
      end
   endtask
   task route(input [4:0] code, input neg);
      begin
         check({11'h000, conn0, conn0 ? idx0 : 4'h0}, {11'h000, pos_exp(code)});
         check({14'h0000, neg0, gnd0}, {14'h0000, neg, code < 5'd10 && port[code[3:0]]});
         check({11'h000, conn0_s, conn0_s ? idx0_s : 4'h0},
            six_ok(code) ? {12'h001, code[3:0]} : 16'h0000);
      end
   endtask
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 30000)
      begin
         failures = failures + 1;
         give_verdict;
      end
   end
   initial
   begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
         rd(i[2:0], 16'h0000);
      check({6'h00, dig_en}, 16'h0000);
      for (i = 0; i < 24; i = i + 1)
      begin
         seed = lfsr(seed);
         d = seed[15:0];
         a = i % 3;
         wr(a, d);
         rd(a, d & (a == 3'h0 ? 16'h9f9f : 16'h03ff));
      end
      port = d[9:0];
      check({6'h00, dig_en}, {6'h00, port});
      check({6'h00, mux_gnd}, {6'h00, port});
      check({6'h00, dig_en_s}, {6'h00, port & 10'h0cf});
      check({6'h00, mux_gnd_s}, {6'h00, port & 10'h0cf});
      wr(3'h3, 16'h0002);
      for (i = 0; i < 32; i = i + 1)
      begin
         seed = lfsr(seed);
         d = {seed[7], 2'b00, seed[4:0], seed[15], 2'b00, i[4:0]};
         wr(3'h0, d);
         settle;
         route(d[4:0], d[7]);
         conv(seed[9]);
         route(d[12:8], d[15]);
         conv(seed[10]);
         check({15'h0000, phase}, 16'h0000);
      end
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(3'h3, {12'h000, i[1], 2'b00, i[0]});
         settle;
         if (i[1])
         begin
            check({13'h0000, conn123}, 16'h0000);
            check({13'h0000, conn123_s}, 16'h0000);
         end
         else
         begin
            check({1'b0, conn123, idx1, idx2, idx3}, i[0] ? 16'h7345 : 16'h7012);
            check({9'h000, conn123_s, idx1_s}, i[0] ? 16'h0013 : 16'h0070);
         end
      end
      // slot 4 has no pin on the six-input part, so it must sample the reference there
      wr(3'h1, 16'h0015);
      wr(3'h3, 16'h0004);
      settle;
      for (i = 0; i < 4; i = i + 1)
      begin
         slot = (i == 3) ? 4'h0 : {1'b0, i[1:0], 1'b0};
         check({10'h000, conn0, nref0, idx0}, {12'h002, slot});
         check({14'h0000, conn0_s, nref0_s}, {14'h0000, i != 2, i == 2});
         conv(i[1]);
      end
      wr(3'h1, 16'h0000);
      settle;
      check({15'h0000, conn0}, 16'h0000);
      give_verdict;
   end
endmodule // adc_input_select_test
